//--- hdl/bafc_regs.svh
// Purpose: Register offsets, field positions, reset values and constants of the codec
// Assumes: 32-bit classic Wishbone, byte addresses, one aligned word per register
// Notes:   Definitions only
`ifndef BAFC_REGS_SVH
`define BAFC_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define BAFC_ADR_CTRL 8'h00
`define BAFC_ADR_DIV 8'h04
`define BAFC_ADR_STATUS 8'h08
`define BAFC_ADR_UNIT 8'h0C
`define BAFC_ADR_MSG 8'h40
`define BAFC_MSG_WORDS 5'h18

// ****************************************
// Control fields and reset values
// ****************************************
`define BAFC_CTRL_TXEN 0
`define BAFC_CTRL_WID_LO 1
`define BAFC_CTRL_AUXEN 3
`define BAFC_CTRL_MODE_LO 4
`define BAFC_CTRL_IGNV 6
`define BAFC_CTRL_RST 32'h0000_0000
`define BAFC_DIV_RST 16'h0010
`define BAFC_STAT_PERR 1

// ****************************************
// Frame layout and patterns
// ****************************************
`define BAFC_LAST_FRAME 8'hBF
`define BAFC_LAST_HALF 6'h3F
`define BAFC_PRE_HALVES 6'h08
`define BAFC_LAST_BIT 5'h1B
`define BAFC_PRE_X 8'hE2
`define BAFC_PRE_Y 8'hE4
`define BAFC_PRE_Z 8'hE8
`define BAFC_TRN_X 8'h93
`define BAFC_TRN_Y 8'h96
`define BAFC_TRN_Z 8'h9C
`define BAFC_CNT_MAX 8'hFF
`define BAFC_USR_BASE 5'h00
`define BAFC_CST_BASE 5'h0C
`define BAFC_CH_WORDS 5'h06

`endif

//--- hdl/bafc_pkg.sv
// Purpose: Types shared by the codec
// Assumes: Constants live in bafc_regs.svh
// Notes:   Gray codes on the receive path
package bafc_pkg;

  // ****************************************
  // Enumerations
  // ****************************************
  typedef enum logic [1:0] {
    BAFC_HUNT = 2'b00, // Waiting for a sync pattern
    BAFC_DATA = 2'b01  // Collecting bits 4..31
  } bafc_rx_e;

  typedef enum logic [1:0] {
    BAFC_SYN_X = 2'b00, // Channel one
    BAFC_SYN_Y = 2'b01, // Channel two
    BAFC_SYN_Z = 2'b11  // Channel one, block start
  } bafc_syn_e;

  typedef enum logic [1:0] {
    BAFC_W16 = 2'b00,
    BAFC_W20 = 2'b01,
    BAFC_W24 = 2'b10,
    BAFC_WRSV = 2'b11
  } bafc_wid_e;

  typedef enum logic [1:0] {
    BAFC_M_INDEP = 2'b00, // Independent or stereo
    BAFC_M_DUP = 2'b01,   // Channel two copies channel one
    BAFC_M_MONO = 2'b10,  // Channel two unused, sent as zero
    BAFC_M_RSV = 2'b11
  } bafc_mode_e;

endpackage : bafc_pkg

//--- hdl/bafc_codec.sv
// Purpose: Bi-phase mark two-channel audio frame encoder and decoder
// Assumes: 100 MHz SYS_CLK; RX_LINE is asynchronous; samples are MSB-aligned in 24 bits
// Notes:   Registers over classic Wishbone; user and status messages read as 24 words
//
// Local design decisions: the Wishbone slave port and the placing of the registers.
`include "bafc_regs.svh"

module bafc_codec
  import bafc_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_B,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Transmit samples and flags
  input wire logic [23:0] TX_CH1_SAMPLE,
  input wire logic [23:0] TX_CH2_SAMPLE,
  input wire logic [3:0] TX_CH1_AUX,
  input wire logic [3:0] TX_CH2_AUX,
  input wire logic [1:0] TX_VALIDITY,
  input wire logic [1:0] TX_USER,
  input wire logic [1:0] TX_CSTAT,
  output logic TX_LOAD,
  // Serial line
  output logic TX_LINE,
  input wire logic RX_LINE,
  // Receive samples and flags
  output logic [23:0] RX_SAMPLE,
  output logic [3:0] RX_AUX,
  output logic RX_CHAN,
  output logic RX_BLOCK_START,
  output logic RX_VALIDITY,
  output logic RX_PAR_ERR,
  output logic RX_STROBE,
  output logic RX_LOCK
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [31:0] ctrl;        // Control register
  logic [15:0] div;         // Half-cell divisor
  logic perr;               // Sticky parity error
  logic [31:0] msg [0:23];  // User and status messages
  logic bus_req;            // Fresh bus request
  logic bus_wr;             // Write request seen with its ack
  logic [31:0] next_rdata;  // Read mux
  logic tx_en;
  bafc_wid_e wid;
  bafc_mode_e mode;
  // Transmit state
  logic [15:0] div_cnt;     // Divider count
  logic tick;               // Half-cell strobe
  logic [5:0] hs;           // Half-cell slot in subframe
  logic sub;                // Subframe in frame
  logic [7:0] tfi;          // Transmit frame index
  logic pinv;               // Line level before sync
  logic [23:0] ts1, ts2;    // Latched samples
  logic [3:0] ta1, ta2;     // Latched aux
  logic [1:0] tv, tu, tc;   // Latched flags
  logic [23:0] smp;         // Masked sample of this subframe
  logic [27:0] wbits;       // Bits 4..31 of this subframe
  logic [7:0] pat;          // Sync pattern of this subframe
  logic [4:0] bidx;         // Bit index into wbits
  // Receive state
  logic [2:0] rx_sync;      // Input synchroniser
  logic rx_lvl, rx_lvl_q;   // Filtered level and delay
  logic edge_seen;
  logic [7:0] cnt;          // Cycles since last edge
  logic [7:0] unit;         // Half-cell estimate
  logic [9:0] c2, u3, u5, u7, c4;
  logic [1:0] n;            // Half-cells in last interval
  logic [7:0] hist, next_hist;
  logic hit;
  bafc_syn_e hit_t, ptype;
  bafc_rx_e st;
  logic ph;                 // Mid-cell phase
  logic [4:0] bitn;
  logic [27:0] d;           // Bits 4..31 received
  logic sf_done;
  logic last_ch1;
  logic [7:0] rfi, cur_fi;
  logic rch;
  logic [4:0] widx;

  assign tx_en = ctrl[`BAFC_CTRL_TXEN];
  assign wid = bafc_wid_e'(ctrl[`BAFC_CTRL_WID_LO +: 2]);
  assign mode = bafc_mode_e'(ctrl[`BAFC_CTRL_MODE_LO +: 2]);

  // ****************************************
  // Wishbone slave
  // ****************************************
  assign bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  // Writes land on the edge at which the master sees the ack
  assign bus_wr = WB_CYC_I & WB_STB_I & WB_WE_I & WB_ACK_O;

  // Ack one cycle after request, dropped next cycle
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      WB_ACK_O <= 1'b0;
    end else begin
      WB_ACK_O <= bus_req;
    end
  end

  // Read mux; unmapped reads return zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (WB_ADR_I == `BAFC_ADR_CTRL) begin
      next_rdata = ctrl;
    end else if (WB_ADR_I == `BAFC_ADR_DIV) begin
      next_rdata = {16'h0000, div};
    end else if (WB_ADR_I == `BAFC_ADR_STATUS) begin
      next_rdata = {14'h0000, tfi, rfi, perr, RX_LOCK};
    end else if (WB_ADR_I == `BAFC_ADR_UNIT) begin
      next_rdata = {24'h00_0000, unit};
    end else if (WB_ADR_I >= `BAFC_ADR_MSG &&
                 WB_ADR_I[7:2] < (`BAFC_ADR_MSG >> 2) + {1'b0, `BAFC_MSG_WORDS}) begin
      next_rdata = msg[5'(WB_ADR_I[7:2] - (`BAFC_ADR_MSG >> 2))];
    end
  end

  // Read data registered with the ack
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      WB_DAT_O <= 32'h0000_0000;
    end else if (bus_req && !WB_WE_I) begin
      WB_DAT_O <= next_rdata;
    end
  end

  // Control and divisor writes, per byte lane
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl <= `BAFC_CTRL_RST;
      div <= `BAFC_DIV_RST;
    end else if (bus_wr) begin
      for (int i = 0; i < 4; i++) begin
        if (WB_SEL_I[i] && WB_ADR_I == `BAFC_ADR_CTRL) begin
          ctrl[i*8 +: 8] <= WB_DAT_I[i*8 +: 8];
        end
      end
      if (WB_ADR_I == `BAFC_ADR_DIV) begin
        if (WB_SEL_I[0]) div[7:0] <= WB_DAT_I[7:0]; // Rate for 32/44.1/48 kHz
        if (WB_SEL_I[1]) div[15:8] <= WB_DAT_I[15:8];
      end
    end
  end

  // ****************************************
  // Transmit word building
  // ****************************************
  // Width masking and aux placement of the current channel
  always_comb begin
    smp = sub ? ts2 : ts1;
    unique case (wid)
      BAFC_W16: smp[7:0] = 8'h00;
      BAFC_W20: smp[3:0] = ctrl[`BAFC_CTRL_AUXEN] ?
                           (sub ? ta2 : ta1) : 4'h0;
      BAFC_W24: smp = smp;
      default: smp = smp;
    endcase
  end

  // Flags after the sample, parity last
  assign wbits[23:0] = smp;
  assign wbits[24] = tv[sub];
  assign wbits[25] = tu[sub];
  assign wbits[26] = tc[sub];
  assign wbits[27] = ^wbits[26:0]; // Even ones over 4..31
  // Sync choice per subframe
  assign pat = sub ? `BAFC_PRE_Y : ((tfi == 8'h00) ? `BAFC_PRE_Z : `BAFC_PRE_X);
  assign bidx = 5'(hs[5:1] - 5'h04);
  assign tick = tx_en && (div_cnt == div - 16'h0001);

  // Half-cell divider
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      div_cnt <= 16'h0000;
    end else if (!tx_en || tick) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  // Slot, subframe and frame counters
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      hs <= 6'h00;
      sub <= 1'b0;
      tfi <= 8'h00;
    end else if (!tx_en) begin
      hs <= 6'h00;
      sub <= 1'b0;
      tfi <= 8'h00;
    end else if (tick) begin
      hs <= hs + 6'h01;
      if (hs == `BAFC_LAST_HALF) begin
        sub <= ~sub;
        if (sub) begin
          tfi <= (tfi == `BAFC_LAST_FRAME) ? 8'h00 : tfi + 8'h01;
        end
      end
    end
  end

  // Line coder
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      TX_LINE <= 1'b0;
      pinv <= 1'b0;
    end else if (!tx_en) begin
      TX_LINE <= 1'b0;
    end else if (tick) begin
      if (hs == 6'h00) begin
        pinv <= TX_LINE;
        TX_LINE <= pat[7] ^ TX_LINE;
      end else if (hs < `BAFC_PRE_HALVES) begin
        TX_LINE <= pat[3'h7 - hs[2:0]] ^ pinv;
      end else if (!hs[0]) begin
        TX_LINE <= ~TX_LINE;                        // Cell start edge
      end else begin
        TX_LINE <= TX_LINE ^ wbits[bidx];           // Mid edge for one
      end
    end
  end

  // Sample latch once per frame, with channel modes
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      TX_LOAD <= 1'b0;
      ts1 <= 24'h00_0000;
      ts2 <= 24'h00_0000;
      ta1 <= 4'h0;
      ta2 <= 4'h0;
      tv <= 2'b00;
      tu <= 2'b00;
      tc <= 2'b00;
    end else begin
      TX_LOAD <= tick && sub && hs == `BAFC_LAST_HALF;
      if (tick && sub && hs == `BAFC_LAST_HALF) begin
        ts1 <= TX_CH1_SAMPLE;
        ta1 <= TX_CH1_AUX;
        tv <= TX_VALIDITY;
        tu <= TX_USER;
        tc <= TX_CSTAT;
        unique case (mode)
          BAFC_M_DUP: begin
            ts2 <= TX_CH1_SAMPLE;
            ta2 <= TX_CH1_AUX;
          end
          BAFC_M_MONO: begin
            ts2 <= 24'h00_0000;                     // Unused channel zero
            ta2 <= 4'h0;
          end
          default: begin
            ts2 <= TX_CH2_SAMPLE;
            ta2 <= TX_CH2_AUX;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Receive clock recovery
  // ****************************************
  // Three-stage synchroniser, level taken when stages two and three agree
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rx_sync <= 3'b000;
      rx_lvl <= 1'b0;
      rx_lvl_q <= 1'b0;
    end else begin
      rx_sync <= {rx_sync[1:0], RX_LINE};
      rx_lvl <= (rx_sync[1] == rx_sync[2]) ? rx_sync[2] : rx_lvl;
      rx_lvl_q <= rx_lvl;
    end
  end

  assign edge_seen = rx_lvl ^ rx_lvl_q; // Either polarity
  assign c2 = {1'b0, cnt, 1'b0};
  assign c4 = {cnt, 2'b00};
  assign u3 = 10'({2'b00, unit} * 10'h003);
  assign u5 = 10'({2'b00, unit} * 10'h005);
  assign u7 = 10'({2'b00, unit} * 10'h007);

  // Interval in half-cells; zero means out of range
  always_comb begin
    if (c2 < u3) begin
      n = 2'h1;
    end else if (c2 < u5) begin
      n = 2'h2;
    end else if (c2 < u7) begin
      n = 2'h3;
    end else begin
      n = 2'h0;
    end
  end

  // Edge spacing counter and half-cell estimate
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cnt <= 8'h00;
      unit <= `BAFC_CNT_MAX;
    end else if (edge_seen) begin
      cnt <= 8'h01;
      if (c4 < u3 && cnt != 8'h00) begin
        unit <= cnt;
      end else if (n == 2'h1) begin
        unit <= 8'(({1'b0, unit} + {1'b0, cnt}) >> 1);
      end
    end else if (cnt == `BAFC_CNT_MAX) begin
      unit <= `BAFC_CNT_MAX;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end

  // ****************************************
  // Receive decoder
  // ****************************************
  // Transition history, one bit per half-cell
  always_comb begin
    unique case (n)
      2'h1: next_hist = {hist[6:0], 1'b1};
      2'h2: next_hist = {hist[5:0], 2'b10};
      2'h3: next_hist = {hist[4:0], 3'b100};
      default: next_hist = 8'h00;
    endcase
    hit = 1'b1;
    hit_t = BAFC_SYN_X;
    if (next_hist == `BAFC_TRN_X) begin       // Both polarities alike
      hit_t = BAFC_SYN_X;
    end else if (next_hist == `BAFC_TRN_Y) begin
      hit_t = BAFC_SYN_Y;
    end else if (next_hist == `BAFC_TRN_Z) begin
      hit_t = BAFC_SYN_Z;
    end else begin
      hit = 1'b0;
    end
  end

  // Subframe state machine
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      hist <= 8'h00;
      st <= BAFC_HUNT;
      ph <= 1'b0;
      bitn <= 5'h00;
      d <= 28'h000_0000;
      ptype <= BAFC_SYN_X;
      sf_done <= 1'b0;
    end else begin
      sf_done <= 1'b0;
      if (edge_seen) begin
        hist <= next_hist;
        if (hit) begin
          st <= BAFC_DATA;                          // Sync fills slots 0..3
          ph <= 1'b0;
          bitn <= 5'h00;
          ptype <= hit_t;
        end else if (st == BAFC_DATA) begin
          unique case ({ph, n})
            3'b0_10, 3'b1_01: begin
              d <= {ph, d[27:1]};                   // Mid edge means one
              ph <= 1'b0;
              bitn <= bitn + 5'h01;
              if (bitn == `BAFC_LAST_BIT) begin
                sf_done <= 1'b1;
                st <= BAFC_HUNT;
              end
            end
            3'b0_01: ph <= 1'b1;
            default: st <= BAFC_HUNT;               // Coding violation
          endcase
        end
      end
    end
  end

  // Lock follows the expected sync order
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      RX_LOCK <= 1'b0;
      last_ch1 <= 1'b0;
    end else if (edge_seen && hit) begin
      RX_LOCK <= (hit_t == BAFC_SYN_Y) == last_ch1;
      last_ch1 <= hit_t != BAFC_SYN_Y;
    end else if ((edge_seen && n == 2'h0) || cnt == `BAFC_CNT_MAX) begin
      RX_LOCK <= 1'b0;
    end
  end

  // Frame index of the finished subframe
  assign rch = ptype == BAFC_SYN_Y;
  always_comb begin
    if (ptype == BAFC_SYN_Z) begin
      cur_fi = 8'h00;
    end else if (ptype == BAFC_SYN_X) begin
      cur_fi = (rfi == `BAFC_LAST_FRAME) ? 8'h00 : rfi + 8'h01;
    end else begin
      cur_fi = rfi;
    end
  end
  assign widx = (rch ? `BAFC_CH_WORDS : 5'h00) + {2'b00, cur_fi[7:5]};

  // Received sample outputs
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      RX_SAMPLE <= 24'h00_0000;
      RX_AUX <= 4'h0;
      RX_CHAN <= 1'b0;
      RX_BLOCK_START <= 1'b0;
      RX_VALIDITY <= 1'b0;
      RX_PAR_ERR <= 1'b0;
      RX_STROBE <= 1'b0;
      rfi <= 8'h00;
    end else begin
      RX_STROBE <= sf_done && (!d[24] || ctrl[`BAFC_CTRL_IGNV]);
      if (sf_done) begin
        rfi <= cur_fi;
        RX_CHAN <= rch;
        RX_BLOCK_START <= ptype == BAFC_SYN_Z;
        RX_VALIDITY <= d[24];
        RX_PAR_ERR <= ^d;
        RX_SAMPLE <= d[23:0];                       // MSB at bit 27
        RX_AUX <= 4'h0;
        unique case (wid)
          BAFC_W16: RX_SAMPLE[7:0] <= 8'h00;
          BAFC_W20: begin
            RX_SAMPLE[3:0] <= 4'h0;
            RX_AUX <= ctrl[`BAFC_CTRL_AUXEN] ? d[3:0] : 4'h0;
          end
          default: RX_SAMPLE <= d[23:0];
        endcase
      end
    end
  end

  // User and status message gathering
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < 24; i++) begin
        msg[i] <= 32'h0000_0000;
      end
    end else if (sf_done) begin
      msg[widx + `BAFC_USR_BASE][cur_fi[4:0]] <= d[25];
      msg[widx + `BAFC_CST_BASE][cur_fi[4:0]] <= d[26];
    end
  end

  // Sticky parity error; a new error wins over the clear
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      perr <= 1'b0;
    end else if (sf_done && ^d) begin
      perr <= 1'b1;
    end else if (bus_wr && WB_ADR_I == `BAFC_ADR_STATUS && WB_SEL_I[0] &&
                 WB_DAT_I[`BAFC_STAT_PERR]) begin
      perr <= 1'b0;
    end
  end

endmodule : bafc_codec

//--- verif/bafc_far_end.sv
// Purpose: Far-end repeater that returns the codec line
// Assumes: Shares the system clock
// Notes:   Can invert the line or freeze it for idle tests
module bafc_far_end (
  // Clock
  input wire logic clk,
  // Control
  input wire logic invert,
  input wire logic freeze,
  // Line
  input wire logic line_in,
  output logic line_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // Retime, optionally flipping polarity
  // ****************************************
  // Frozen line keeps its level to starve the receiver of edges
  always_ff @(posedge clk) begin
    if (!freeze) begin
      line_out <= line_in ^ invert;
    end
  end
endmodule : bafc_far_end

//--- verif/bafc_codec_assertions.sv
// Purpose: Checker of bus, pulse and lock timing
// Assumes: Sees only top-level ports
// Notes:   Bound at the foot of this file
module bafc_codec_chk (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_B,
  // Bus
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  // Line and stream
  input wire logic TX_LOAD,
  input wire logic TX_LINE,
  input wire logic RX_LINE,
  input wire logic RX_CHAN,
  input wire logic RX_BLOCK_START,
  input wire logic RX_STROBE,
  input wire logic RX_LOCK
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_B);
  // ****************************************
  // Idle time of the incoming line
  // ****************************************
  logic [8:0] idle_cnt; // Cycles without a change
  logic line_q; // Previous line sample
  // Saturating count, cleared by any change
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      idle_cnt <= 9'h000;
      line_q <= 1'b0;
    end else begin
      line_q <= RX_LINE;
      if (RX_LINE != line_q) begin
        idle_cnt <= 9'h000;
      end else if (idle_cnt != 9'h1FF) begin
        idle_cnt <= idle_cnt + 9'h001;
      end
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  sequence s_bus_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_bus_ans;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence
  AST_BUS_ACK: assert property (s_bus_req |=> s_bus_ans)
    else $error("bus request not answered in one cycle");
  AST_ACK_CAUSE: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without request");
  AST_LOAD_GAP: assert property (TX_LOAD |=> !TX_LOAD [*8])
    else $error("frame loads too close");
  AST_STROBE_GAP: assert property (RX_STROBE |=> !RX_STROBE [*8])
    else $error("receive strobes too close");
  AST_Z_ON_CH1: assert property (RX_STROBE && RX_BLOCK_START |-> !RX_CHAN)
    else $error("block start on channel two");
  AST_IDLE_UNLOCK: assert property (idle_cnt > 9'h10E |-> !RX_LOCK)
    else $error("lock held on idle line");
  AST_LOCK_ACTIVE: assert property ($rose(RX_LOCK) |-> idle_cnt < 9'h0FF)
    else $error("lock gained without edges");
  AST_RESET_QUIET: assert property ($rose(RST_B) |->
    !(WB_ACK_O || TX_LOAD || TX_LINE || RX_STROBE || RX_LOCK))
    else $error("outputs active after reset");
endmodule : bafc_codec_chk

bind bafc_codec bafc_codec_chk u_chk (
  .SYS_CLK(SYS_CLK),
  .RST_B(RST_B),
  .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I),
  .WB_ACK_O(WB_ACK_O),
  .TX_LOAD(TX_LOAD),
  .TX_LINE(TX_LINE),
  .RX_LINE(RX_LINE),
  .RX_CHAN(RX_CHAN),
  .RX_BLOCK_START(RX_BLOCK_START),
  .RX_STROBE(RX_STROBE),
  .RX_LOCK(RX_LOCK)
);

//--- verif/bafc_codec_tb.sv
// Purpose: Self-checking bench of the codec in line loopback
// Assumes: Far-end model returns TX_LINE on RX_LINE
// Notes:   Half-cell shortened to five clocks
`include "bafc_regs.svh"
module bafc_codec_tb
  import bafc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // Signals
  // ****************************************
  logic SYS_CLK, RST_B, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O;
  logic [7:0] WB_ADR_I;
  logic [3:0] WB_SEL_I, TX_CH1_AUX, TX_CH2_AUX, RX_AUX;
  logic [31:0] WB_DAT_I, WB_DAT_O;
  logic [23:0] TX_CH1_SAMPLE, TX_CH2_SAMPLE, RX_SAMPLE;
  logic [1:0] TX_VALIDITY, TX_USER, TX_CSTAT;
  logic TX_LOAD, TX_LINE, RX_LINE, RX_CHAN, RX_BLOCK_START, RX_VALIDITY;
  logic RX_PAR_ERR, RX_STROBE, RX_LOCK, invert, freeze;
  int n_mismatch = 0;
  int n_compared = 0;
  localparam logic [23:0] smp1 = 24'h9A_5C3B; // Negative sample
  localparam logic [23:0] smp2 = 24'h65_A3C7; // Positive sample

  bafc_codec DUT (.SYS_CLK, .RST_B, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I,
    .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .TX_CH1_SAMPLE, .TX_CH2_SAMPLE,
    .TX_CH1_AUX, .TX_CH2_AUX, .TX_VALIDITY, .TX_USER, .TX_CSTAT, .TX_LOAD,
    .TX_LINE, .RX_LINE, .RX_SAMPLE, .RX_AUX, .RX_CHAN, .RX_BLOCK_START,
    .RX_VALIDITY, .RX_PAR_ERR, .RX_STROBE, .RX_LOCK);
  bafc_far_end u_far (.clk(SYS_CLK), .invert(invert), .freeze(freeze),
    .line_in(TX_LINE), .line_out(RX_LINE));

  // 100 MHz clock
  initial begin
    SYS_CLK = 1'b0;
    forever begin
      #5 SYS_CLK = ~SYS_CLK;
    end
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  task automatic timeout();
    n_mismatch++;
    $display("MISMATCH wait expected event seen timeout");
    finish_test();
  endtask : timeout

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Classic single cycle; held until ack is sampled
  task automatic wb_io(input logic we, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
    int n;
    n = 0;
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= a;
    WB_DAT_I <= wd;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (WB_ACK_O !== 1'b1 && n < 50);
    if (n >= 50) timeout();
    rd = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    @(posedge SYS_CLK);
  endtask : wb_io

  // Wait for a strobe of the given channel
  task automatic get_sub(input logic ch);
    int n;
    n = 0;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (!(RX_STROBE === 1'b1 && RX_CHAN === ch) && n < 9000);
    if (n >= 9000) timeout();
  endtask : get_sub

  function automatic logic [31:0] mk(bafc_wid_e w, logic ax, bafc_mode_e m, logic ig);
    logic [31:0] c;
    c = 32'h0000_0000;
    c[`BAFC_CTRL_TXEN] = 1'b1;
    c[`BAFC_CTRL_WID_LO +: 2] = w;
    c[`BAFC_CTRL_AUXEN] = ax;
    c[`BAFC_CTRL_MODE_LO +: 2] = m;
    c[`BAFC_CTRL_IGNV] = ig;
    return c;
  endfunction : mk

  // Configure, let three frames pass, check both channels
  task automatic run(input logic [31:0] ctrl, input logic [23:0] e1,
                     input logic [23:0] e2, input logic ev);
    logic [31:0] d;
    wb_io(1'b1, `BAFC_ADR_CTRL, ctrl, d);
    repeat (3) get_sub(1'b0);
    chk("ch1 sample", {8'h00, e1}, {8'h00, RX_SAMPLE});
    get_sub(1'b1);
    chk("ch2 sample", {8'h00, e2}, {8'h00, RX_SAMPLE});
    chk("validity", {31'h0, ev}, {31'h0, RX_VALIDITY});
    chk("ch2 block start", 32'h0, {31'h0, RX_BLOCK_START});
    chk("parity err", 32'h0, {31'h0, RX_PAR_ERR});
  endtask : run
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] d;
    logic [31:0] c2;
    int n;
    int k;
    RST_B = 1'b0;
    {WB_CYC_I, WB_STB_I, WB_WE_I, invert, freeze} = 5'h00;
    {WB_ADR_I, WB_DAT_I, TX_VALIDITY} = 42'h000_0000_0000;
    WB_SEL_I = 4'hF;
    TX_CH1_SAMPLE = smp1;
    TX_CH2_SAMPLE = smp2;
    {TX_CH1_AUX, TX_CH2_AUX} = 8'h5A;
    TX_USER = 2'h1;
    TX_CSTAT = 2'h2;
    repeat (6) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    @(posedge SYS_CLK);
    wb_io(1'b0, `BAFC_ADR_CTRL, 32'h0000_0000, d);
    chk("ctrl reset", `BAFC_CTRL_RST, d);
    wb_io(1'b0, `BAFC_ADR_DIV, 32'h0000_0000, d);
    chk("div reset", {16'h0000, `BAFC_DIV_RST}, d);
    wb_io(1'b0, 8'h30, 32'h0000_0000, d);
    chk("unmapped", 32'h0000_0000, d);
    wb_io(1'b1, `BAFC_ADR_DIV, 32'h0000_0005, d);
    run(mk(BAFC_W24, 1'b0, BAFC_M_INDEP, 1'b0), smp1, smp2, 1'b0);
    wb_io(1'b0, `BAFC_ADR_STATUS, 32'h0000_0000, d);
    chk("lock", 32'h1, {31'h0, d[0]});
    wb_io(1'b0, `BAFC_ADR_MSG, 32'h0000_0000, d);
    chk("user ch1", 32'h1, {31'h0, d[3]});
    wb_io(1'b0, 8'h58, 32'h0000_0000, d);
    chk("user ch2", 32'h0, {31'h0, d[3]});
    wb_io(1'b0, 8'h88, 32'h0000_0000, d);
    chk("status ch2", 32'h1, {31'h0, d[3]});
    run(mk(BAFC_W20, 1'b1, BAFC_M_INDEP, 1'b0), smp1 & 24'hFF_FFF0,
        smp2 & 24'hFF_FFF0, 1'b0);
    chk("aux", 32'hA, {28'h0, RX_AUX});
    run(mk(BAFC_W16, 1'b0, BAFC_M_INDEP, 1'b0), smp1 & 24'hFF_FF00,
        smp2 & 24'hFF_FF00, 1'b0);
    run(mk(BAFC_W24, 1'b0, BAFC_M_DUP, 1'b0), smp1, smp1, 1'b0);
    run(mk(BAFC_W24, 1'b0, BAFC_M_MONO, 1'b0), smp1, 24'h00_0000, 1'b0);
    invert <= 1'b1;
    run(mk(BAFC_W24, 1'b0, BAFC_M_INDEP, 1'b0), smp1, smp2, 1'b0);
    invert <= 1'b0;
    TX_VALIDITY <= 2'h2;
    run(mk(BAFC_W24, 1'b0, BAFC_M_INDEP, 1'b1), smp1, smp2, 1'b1);
    wb_io(1'b1, `BAFC_ADR_CTRL, mk(BAFC_W24, 1'b0, BAFC_M_INDEP, 1'b0), d);
    repeat (3) get_sub(1'b0);
    // Count channel-two strobes over two frames
    n = 0;
    k = 0;
    c2 = 32'h0;
    while (k < 2 && n < 9000) begin
      @(posedge SYS_CLK);
      n++;
      if (RX_STROBE === 1'b1 && RX_CHAN === 1'b1) c2++;
      if (RX_STROBE === 1'b1 && RX_CHAN === 1'b0) k++;
    end
    if (n >= 9000) timeout();
    chk("ch2 strobes", 32'h0, c2);
    // Starve the receiver of edges
    freeze <= 1'b1;
    n = 0;
    while (RX_LOCK !== 1'b0 && n < 400) begin
      @(posedge SYS_CLK);
      n++;
    end
    chk("lock lost", 32'h0, {31'h0, RX_LOCK});
    finish_test();
  end
endmodule : bafc_codec_tb
